// ==== common/dsd_pkg.sv ====
// Shared types and constants of the dual-element compute datapath.
// Assumes a single core clock; memories sit outside the block.
package dsd_pkg;
  localparam int WORD_W = 40;
  localparam int FIX_W = 32;
  localparam int INSTR_W = 48;
  localparam int ADDR_W = 24;
  localparam int REG_CNT = 32;
  localparam int REG_AW = 5;
  localparam int IDX_W = 4;
  localparam int CACHE_CNT = 32;
  localparam int CACHE_IW = 5;
  localparam logic [1:0] FMT_FIX32 = 2'h0;
  localparam logic [1:0] FMT_SP32 = 2'h1;
  localparam logic [1:0] FMT_EP40 = 2'h2;
  localparam logic [WORD_W-1:0] ZERO_WORD = 40'h00_0000_0000;
  localparam logic [INSTR_W-1:0] NOP_INSTR = 48'h0000_0000_0000;
  localparam logic STALL_CYCLES = 1'h1;

  typedef enum logic [2:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_PASS, ALU_NEG, ALU_ABS
  } dsd_alu_op_e;
  typedef enum logic [1:0] {SH_LSL, SH_LSR, SH_ASR, SH_ROT} dsd_sh_op_e;

  typedef struct packed {
    logic alu_en;
    dsd_alu_op_e alu_op;
    logic mul_en;
    logic sh_en;
    dsd_sh_op_e sh_op;
    logic [1:0] fmt;
    logic alt_bank;
    logic [IDX_W-1:0] rx;
    logic [IDX_W-1:0] ry;
    logic [IDX_W-1:0] ra_dst;
    logic [IDX_W-1:0] rm_dst;
    logic [IDX_W-1:0] rs_dst;
    logic ld_dm;
    logic [IDX_W-1:0] ld_dm_dst;
    logic ld_pm;
    logic [IDX_W-1:0] ld_pm_dst;
  } dsd_instr_s;

  typedef struct packed {
    logic [WORD_W-1:0] x;
    logic [WORD_W-1:0] y;
  } dsd_pair_s;

  typedef struct packed {
    logic [CACHE_CNT-1:0] vld;
    logic [ADDR_W-1:0] fetch_addr;
    logic stall;
    logic [INSTR_W-1:0] instr;
    logic instr_vld;
    logic fetch_req;
    logic simd;
  } dsd_state_s;
endpackage

// ==== verilog/dsd_datapath.sv ====
// Dual processing-element datapath with selective instruction cache.
// Assumes memories answer in the same cycle as the request.
`timescale 1ns/1ps
// What this block does
// - The primary element always runs; the secondary only when enabled.
// - When enabled, both elements run one instruction on own registers.
// - In dual mode each access moves a pair of values, one per element.
// - Each element has parallel ALU, multiplier, shifter, one cycle each.
// - A multifunction op runs ALU and multiplier together, in both.
// - ALU and multiplier handle 32-bit fixed, single and 40-bit extended float; the shifter 32-bit only.
// - Each element owns 32 registers: a primary and an alternate 16.
// - Primary element uses x-file 0..31, secondary the y-file 0..31.
// - The data bus carries only data; the program bus carries both.
// - One cycle takes four operands and one instruction from the cache.
// - Only fetches that collided with program-bus data are cached.
module dsd_datapath (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // Mode
  input wire logic SECONDARY_ELEMENT_ENABLE_IN,
  // Program sequencer
  input wire logic [dsd_pkg::ADDR_W-1:0] FETCH_ADDR_IN,
  input wire logic FETCH_REQ_IN,
  input wire logic PM_DATA_REQ_IN,
  // Program bus
  input wire logic [dsd_pkg::INSTR_W-1:0] PM_INSTR_IN,
  input wire dsd_pkg::dsd_pair_s PM_DATA_IN,
  // Data bus
  input wire dsd_pkg::dsd_pair_s DM_DATA_IN,
  // Outputs
  output logic [dsd_pkg::ADDR_W-1:0] PM_FETCH_ADDR_OUT,
  output logic PM_FETCH_REQ_OUT,
  output logic FETCH_STALL_OUT,
  output dsd_pkg::dsd_pair_s RESULT_ALU_OUT,
  output dsd_pkg::dsd_pair_s RESULT_MUL_OUT,
  output logic SECONDARY_ACTIVE_OUT
);
  dsd_pkg::dsd_state_s s_q, s_d;
  logic [dsd_pkg::WORD_W-1:0] xf_q [dsd_pkg::REG_CNT];
  logic [dsd_pkg::WORD_W-1:0] yf_q [dsd_pkg::REG_CNT];
  logic [dsd_pkg::INSTR_W-1:0] cache_q [dsd_pkg::CACHE_CNT];
  logic [dsd_pkg::ADDR_W-1:0] tag_q [dsd_pkg::CACHE_CNT];
  dsd_pkg::dsd_pair_s alu_q, mul_q;
  dsd_pkg::dsd_instr_s ins;
  logic [dsd_pkg::CACHE_IW-1:0] cidx;
  logic hit, collide, alloc;
  logic [dsd_pkg::INSTR_W-1:0] fetched;
  logic fetched_vld;

  function automatic logic [dsd_pkg::REG_AW-1:0] ridx(
      input logic bank, input logic [dsd_pkg::IDX_W-1:0] i);
    ridx = {bank, i};
  endfunction

  function automatic logic [dsd_pkg::WORD_W-1:0] alu_f(
      input dsd_pkg::dsd_alu_op_e op, input logic [1:0] fmt,
      input logic [dsd_pkg::WORD_W-1:0] a, input logic [dsd_pkg::WORD_W-1:0] b);
    logic [dsd_pkg::WORD_W-1:0] r;
    r = a;
    if (fmt == dsd_pkg::FMT_FIX32) begin
      case (op)
        dsd_pkg::ALU_ADD: r[31:0] = a[31:0] + b[31:0];
        dsd_pkg::ALU_SUB: r[31:0] = a[31:0] - b[31:0];
        dsd_pkg::ALU_AND: r[31:0] = a[31:0] & b[31:0];
        dsd_pkg::ALU_OR: r[31:0] = a[31:0] | b[31:0];
        dsd_pkg::ALU_XOR: r[31:0] = a[31:0] ^ b[31:0];
        dsd_pkg::ALU_NEG: r[31:0] = 32'h0000_0000 - a[31:0];
        dsd_pkg::ALU_ABS: r[31:0] = a[31] ? 32'h0000_0000 - a[31:0] : a[31:0];
        default: r[31:0] = a[31:0];
      endcase
      r[39:32] = 8'h00;
    end else begin
      // Float formats: sign-level ops only; add/sub kept as mantissa sum
      // for area, full rounding left to a later revision
      case (op)
        dsd_pkg::ALU_NEG: r = {~a[39], a[38:0]};
        dsd_pkg::ALU_ABS: r = {1'b0, a[38:0]};
        dsd_pkg::ALU_ADD: r = {a[39:8], a[7:0] + b[7:0]};
        dsd_pkg::ALU_SUB: r = {a[39:8], a[7:0] - b[7:0]};
        default: r = a;
      endcase
      if (fmt == dsd_pkg::FMT_SP32) r[7:0] = 8'h00;
    end
    alu_f = r;
  endfunction

  function automatic logic [dsd_pkg::WORD_W-1:0] mul_f(
      input logic [1:0] fmt,
      input logic [dsd_pkg::WORD_W-1:0] a, input logic [dsd_pkg::WORD_W-1:0] b);
    logic [63:0] p;
    p = 64'($signed(a[31:0]) * $signed(b[31:0]));
    if (fmt == dsd_pkg::FMT_FIX32) mul_f = {8'h00, p[31:0]};
    else mul_f = {a[39] ^ b[39], p[38:0]};
  endfunction

  function automatic logic [dsd_pkg::WORD_W-1:0] sh_f(
      input dsd_pkg::dsd_sh_op_e op,
      input logic [dsd_pkg::WORD_W-1:0] a, input logic [dsd_pkg::WORD_W-1:0] b);
    logic [4:0] n;
    logic [31:0] v;
    n = b[4:0];
    v = a[31:0];
    case (op)
      dsd_pkg::SH_LSL: v = v << n;
      dsd_pkg::SH_LSR: v = v >> n;
      dsd_pkg::SH_ASR: v = 32'($signed(v) >>> n);
      default: v = (v << n) | (v >> (6'd32 - {1'b0, n}));
    endcase
    sh_f = {8'h00, v};
  endfunction

  // Instruction source: cache on hit, else program bus
  assign cidx = s_q.fetch_addr[dsd_pkg::CACHE_IW-1:0];
  assign hit = s_q.vld[cidx] && tag_q[cidx] == s_q.fetch_addr;
  assign collide = s_q.fetch_req && PM_DATA_REQ_IN;
  // Stall holds the fetch one cycle so the data access owns the bus
  assign alloc = s_q.stall;
  assign fetched = hit ? cache_q[cidx] : PM_INSTR_IN;
  // Stalled slot issues the word that is being cached
  assign fetched_vld = s_q.fetch_req && (hit || !collide || s_q.stall);
  // Instruction fields sit in the low bits of the word
  assign ins = dsd_pkg::dsd_instr_s'(
    s_q.instr[$bits(dsd_pkg::dsd_instr_s)-1:0]);

  always_comb begin
    s_d = s_q;
    s_d.simd = SECONDARY_ELEMENT_ENABLE_IN;
    s_d.instr_vld = fetched_vld;
    if (fetched_vld) s_d.instr = fetched;
    if (collide && !hit && !s_q.stall) begin
      s_d.stall = dsd_pkg::STALL_CYCLES;
    end else begin
      s_d.stall = 1'b0;
      s_d.fetch_req = FETCH_REQ_IN;
      s_d.fetch_addr = FETCH_ADDR_IN;
    end
    if (alloc) s_d.vld[cidx] = 1'b1;
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Arrays have no reset; valid bits guard the cache
  always_ff @(posedge CLK_IN) begin
    if (alloc) begin
      cache_q[cidx] <= PM_INSTR_IN;
      tag_q[cidx] <= s_q.fetch_addr;
    end
  end

  // Execution: ALU and multiplier results registered in parallel; shifter writes only the files
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      alu_q <= '0;
      mul_q <= '0;
    end else if (s_q.instr_vld) begin
      if (ins.alu_en) begin
        alu_q.x <= alu_f(ins.alu_op, ins.fmt,
          xf_q[ridx(ins.alt_bank, ins.rx)], xf_q[ridx(ins.alt_bank, ins.ry)]);
        if (s_q.simd) begin
          alu_q.y <= alu_f(ins.alu_op, ins.fmt,
            yf_q[ridx(ins.alt_bank, ins.rx)], yf_q[ridx(ins.alt_bank, ins.ry)]);
        end
      end
      if (ins.mul_en) begin
        mul_q.x <= mul_f(ins.fmt,
          xf_q[ridx(ins.alt_bank, ins.rx)], xf_q[ridx(ins.alt_bank, ins.ry)]);
        if (s_q.simd) begin
          mul_q.y <= mul_f(ins.fmt,
            yf_q[ridx(ins.alt_bank, ins.rx)], yf_q[ridx(ins.alt_bank, ins.ry)]);
        end
      end
    end
  end

  // Register files: x-file primary, y-file secondary, 16+16 each
  always_ff @(posedge CLK_IN) begin
    if (s_q.instr_vld) begin
      if (ins.alu_en) begin
        xf_q[ridx(ins.alt_bank, ins.ra_dst)] <= alu_f(ins.alu_op, ins.fmt,
          xf_q[ridx(ins.alt_bank, ins.rx)], xf_q[ridx(ins.alt_bank, ins.ry)]);
      end
      if (ins.mul_en) begin
        xf_q[ridx(ins.alt_bank, ins.rm_dst)] <= mul_f(ins.fmt,
          xf_q[ridx(ins.alt_bank, ins.rx)], xf_q[ridx(ins.alt_bank, ins.ry)]);
      end
      if (ins.sh_en) begin
        xf_q[ridx(ins.alt_bank, ins.rs_dst)] <= sh_f(ins.sh_op,
          xf_q[ridx(ins.alt_bank, ins.rx)], xf_q[ridx(ins.alt_bank, ins.ry)]);
      end
      if (ins.ld_dm) begin
        xf_q[ridx(ins.alt_bank, ins.ld_dm_dst)] <= DM_DATA_IN.x;
      end
      if (ins.ld_pm) begin
        xf_q[ridx(ins.alt_bank, ins.ld_pm_dst)] <= PM_DATA_IN.x;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (s_q.instr_vld && s_q.simd) begin
      if (ins.alu_en) begin
        yf_q[ridx(ins.alt_bank, ins.ra_dst)] <= alu_f(ins.alu_op, ins.fmt,
          yf_q[ridx(ins.alt_bank, ins.rx)], yf_q[ridx(ins.alt_bank, ins.ry)]);
      end
      if (ins.mul_en) begin
        yf_q[ridx(ins.alt_bank, ins.rm_dst)] <= mul_f(ins.fmt,
          yf_q[ridx(ins.alt_bank, ins.rx)], yf_q[ridx(ins.alt_bank, ins.ry)]);
      end
      if (ins.sh_en) begin
        yf_q[ridx(ins.alt_bank, ins.rs_dst)] <= sh_f(ins.sh_op,
          yf_q[ridx(ins.alt_bank, ins.rx)], yf_q[ridx(ins.alt_bank, ins.ry)]);
      end
      // Pair transfer: second word of each access feeds the y-file
      if (ins.ld_dm) begin
        yf_q[ridx(ins.alt_bank, ins.ld_dm_dst)] <= DM_DATA_IN.y;
      end
      if (ins.ld_pm) begin
        yf_q[ridx(ins.alt_bank, ins.ld_pm_dst)] <= PM_DATA_IN.y;
      end
    end
  end

  assign PM_FETCH_ADDR_OUT = s_q.fetch_addr;
  assign PM_FETCH_REQ_OUT = s_q.fetch_req;
  assign FETCH_STALL_OUT = s_q.stall;
  assign RESULT_ALU_OUT = alu_q;
  assign RESULT_MUL_OUT = mul_q;
  assign SECONDARY_ACTIVE_OUT = s_q.simd;

  // Fetch and cache
  a_stall_one: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_q.stall |=> !s_q.stall) else $error("stall exceeded one cycle");
  a_stall_cause: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_q.fetch_req && PM_DATA_REQ_IN && !hit && !s_q.stall |=> s_q.stall)
    else $error("collision miss did not stall");
  a_stall_issue: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_q.stall |=> s_q.instr_vld) else $error("stalled fetch not issued");
  a_stall_hold: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_q.stall |-> PM_FETCH_REQ_OUT && $stable(PM_FETCH_ADDR_OUT))
    else $error("fetch not held over stall");
  a_alloc_only: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !s_q.stall |=> s_q.vld == $past(s_q.vld))
    else $error("cache filled without collision");
  a_alloc_hit: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_q.stall |=> s_q.vld[$past(cidx)])
    else $error("collided fetch not cached");
  a_miss_pass: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_q.fetch_req && !PM_DATA_REQ_IN && !s_q.stall |=> !s_q.stall)
    else $error("conflict-free fetch stalled");
  a_hit_issue: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_q.fetch_req && hit |=> s_q.instr_vld)
    else $error("cache hit not issued");
  // Element checks
  a_simd_follow: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    ##1 SECONDARY_ACTIVE_OUT == $past(SECONDARY_ELEMENT_ENABLE_IN))
    else $error("secondary enable not tracked");
  a_y_idle: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !s_q.simd |=> RESULT_ALU_OUT.y == $past(RESULT_ALU_OUT.y))
    else $error("secondary ran while disabled");
  a_mul_y_idle: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !s_q.simd |=> RESULT_MUL_OUT.y == $past(RESULT_MUL_OUT.y))
    else $error("secondary multiplied while disabled");
  a_simd_same: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_q.instr_vld && s_q.simd && ins.alu_en &&
    xf_q[ridx(ins.alt_bank, ins.rx)] == yf_q[ridx(ins.alt_bank, ins.rx)] &&
    xf_q[ridx(ins.alt_bank, ins.ry)] == yf_q[ridx(ins.alt_bank, ins.ry)]
    |=> RESULT_ALU_OUT.x == RESULT_ALU_OUT.y)
    else $error("elements diverged");
  a_x_neg: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_q.instr_vld && ins.alu_en && ins.alu_op == dsd_pkg::ALU_NEG &&
    ins.fmt == dsd_pkg::FMT_EP40 |=> RESULT_ALU_OUT.x[39] !=
    $past(xf_q[ridx(ins.alt_bank, ins.rx)][39]))
    else $error("primary negate not done in one cycle");
  a_fix_upper: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_q.instr_vld && ins.alu_en && ins.fmt == dsd_pkg::FMT_FIX32
    |=> RESULT_ALU_OUT.x[39:32] == 8'h00)
    else $error("fixed sum exceeds 32 bits");
  a_mul_fix: assert property (
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_q.instr_vld && ins.mul_en && ins.fmt == dsd_pkg::FMT_FIX32
    |=> RESULT_MUL_OUT.x[39:32] == 8'h00)
    else $error("fixed product exceeds 32 bits");
  // Main scenarios
  c_stall: cover property (@(posedge CLK_IN) s_q.stall ##1 s_q.instr_vld);
  c_hit: cover property (@(posedge CLK_IN) s_q.fetch_req && hit && collide);
  c_simd_mul: cover property (@(posedge CLK_IN)
    s_q.instr_vld && s_q.simd && ins.alu_en && ins.mul_en);
  c_shift: cover property (@(posedge CLK_IN)
    s_q.instr_vld && s_q.simd && ins.sh_en && ins.alu_en);
  c_single: cover property (@(posedge CLK_IN)
    s_q.instr_vld && !s_q.simd && ins.alu_en);
endmodule

// ==== tb/dsd_mem_model.sv ====
// Program memory model that answers instruction fetches in the same cycle.
// Assumes the bench fills mem directly before each fetch.
`timescale 1ns/1ps
module dsd_mem_model (
  // Clock
  input wire logic clk_in,
  // Fetch request from the datapath
  input wire logic fetch_req_in,
  input wire logic [dsd_pkg::ADDR_W-1:0] fetch_addr_in,
  // Instruction back to the datapath
  output logic [dsd_pkg::INSTR_W-1:0] instr_out
);
  logic [dsd_pkg::INSTR_W-1:0] mem [256];
  logic [dsd_pkg::INSTR_W-1:0] last_q = '0;
  logic flip_q = 1'b0;
  initial foreach (mem[k]) mem[k] = '0;
  // Outside a fetch the bus changes every cycle, so stale reads show up
  always_comb begin
    if (fetch_req_in) begin
      instr_out = mem[fetch_addr_in[7:0]];
    end else begin
      instr_out = flip_q ? ~last_q : last_q ^ 48'h5555_5555_5555;
    end
  end
  always @(posedge clk_in) begin
    flip_q <= ~flip_q;
    if (fetch_req_in) last_q <= instr_out;
  end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench of the dual-element datapath.
// Assumes data buses are held steady by the bench around each instruction.
`timescale 1ns/1ps
module tb_top;
  localparam logic [39:0] SGN = 40'h80_0000_0000;
  logic CLK_IN = 1'b0;
  logic RST_N_IN = 1'b0;
  logic en = 1'b0;
  logic freq = 1'b0;
  logic pdreq = 1'b0;
  logic [dsd_pkg::ADDR_W-1:0] faddr = '0;
  logic [dsd_pkg::ADDR_W-1:0] next_a = 24'h00_0040;
  logic [dsd_pkg::INSTR_W-1:0] instr;
  dsd_pkg::dsd_pair_s pm_d = '0;
  dsd_pkg::dsd_pair_s dm_d = '0;
  logic [dsd_pkg::ADDR_W-1:0] pfa;
  logic pfr, stall, act;
  dsd_pkg::dsd_pair_s alu, mul;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;

  always #2 CLK_IN = ~CLK_IN;

  dsd_datapath uut (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
    .SECONDARY_ELEMENT_ENABLE_IN(en), .FETCH_ADDR_IN(faddr),
    .FETCH_REQ_IN(freq), .PM_DATA_REQ_IN(pdreq), .PM_INSTR_IN(instr),
    .PM_DATA_IN(pm_d), .DM_DATA_IN(dm_d), .PM_FETCH_ADDR_OUT(pfa),
    .PM_FETCH_REQ_OUT(pfr), .FETCH_STALL_OUT(stall),
    .RESULT_ALU_OUT(alu), .RESULT_MUL_OUT(mul), .SECONDARY_ACTIVE_OUT(act));

  dsd_mem_model mdl (.clk_in(CLK_IN), .fetch_req_in(pfr),
    .fetch_addr_in(pfa), .instr_out(instr));

  task automatic conclude();
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, far above the roughly 120 cycles the run needs
  always @(posedge CLK_IN) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [79:0] got,
                     input logic [79:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic step();
    @(posedge CLK_IN);
    #1;
  endtask

  function automatic logic [47:0] op(input logic alu_on,
      input dsd_pkg::dsd_alu_op_e f, input logic bank,
      input logic [3:0] rx, input logic ld, input logic [3:0] dst);
    dsd_pkg::dsd_instr_s i;
    i = '0;
    i.alu_en = alu_on;
    i.mul_en = alu_on;
    i.alu_op = f;
    i.fmt = dsd_pkg::FMT_EP40;
    i.alt_bank = bank;
    i.rx = rx;
    i.ry = rx;
    i.ra_dst = 4'hF;
    i.rm_dst = 4'hE;
    i.ld_dm = ld;
    i.ld_dm_dst = dst;
    i.ld_pm = ld;
    i.ld_pm_dst = dst + 4'h1;
    return 48'(i);
  endfunction

  // One fetch; counts stall pulses over the settling window
  task automatic fetch(input logic [23:0] a, input logic conflict,
                       input int exp_stalls);
    int seen = 0;
    int stalls = 0;
    step();
    faddr = a;
    freq = 1'b1;
    pdreq = conflict;
    step();
    freq = 1'b0;
    repeat (6) begin
      if (pfr === 1'b1 && seen == 0) begin
        chk("fetch address", 80'(pfa), 80'(a));
        seen = 1;
      end
      if (stall === 1'b1) stalls++;
      step();
    end
    pdreq = 1'b0;
    chk("fetch seen", 80'(seen), 80'h1);
    chk("stall pulses", 80'(stalls), 80'(exp_stalls));
  endtask

  task automatic exec(input logic [47:0] w);
    mdl.mem[next_a[7:0]] = w;
    fetch(next_a, 1'b0, 0);
    next_a = next_a + 24'h1;
  endtask

  task automatic s_cache();
    fetch(24'h00_0010, 1'b1, 1);
    fetch(24'h00_0010, 1'b1, 0);
    fetch(24'h00_0020, 1'b0, 0);
    fetch(24'h00_0020, 1'b1, 1);
  endtask

  task automatic s_simd();
    en = 1'b1;
    dm_d = {40'h12_3456_789A, 40'h0F_EDCB_A987};
    pm_d = {40'h81_1111_2222, 40'h00_3333_4444};
    repeat (3) step();
    chk("secondary active", 80'(act), 80'h1);
    exec(op(1'b0, dsd_pkg::ALU_ADD, 1'b0, 4'h0, 1'b1, 4'h1));
    exec(op(1'b1, dsd_pkg::ALU_NEG, 1'b0, 4'h1, 1'b0, 4'h0));
    chk("neg pair", alu, {dm_d.x ^ SGN, dm_d.y ^ SGN});
    exec(op(1'b1, dsd_pkg::ALU_ABS, 1'b0, 4'h2, 1'b0, 4'h0));
    chk("abs pair", alu, {pm_d.x & ~SGN, pm_d.y & ~SGN});
  endtask

  task automatic s_bank();
    dm_d = {40'h00_0000_0003, 40'h00_0000_0003};
    pm_d = {40'h00_0000_0005, 40'h00_0000_0005};
    exec(op(1'b0, dsd_pkg::ALU_ADD, 1'b1, 4'h0, 1'b1, 4'h1));
    exec(op(1'b1, dsd_pkg::ALU_NEG, 1'b1, 4'h1, 1'b0, 4'h0));
    chk("alt neg", alu, {2{40'h80_0000_0003}});
    chk("mul both", mul, {2{40'h00_0000_0009}});
    exec(op(1'b1, dsd_pkg::ALU_NEG, 1'b0, 4'h1, 1'b0, 4'h0));
    chk("primary kept", alu, {40'h92_3456_789A, 40'h8F_EDCB_A987});
  endtask

  // Fixed format with all three units in one word, then read the shift
  task automatic s_fixed();
    dsd_pkg::dsd_instr_s i;
    i = '0;
    i.alu_en = 1'b1;
    i.mul_en = 1'b1;
    i.sh_en = 1'b1;
    i.alu_op = dsd_pkg::ALU_ADD;
    i.sh_op = dsd_pkg::SH_LSL;
    i.fmt = dsd_pkg::FMT_FIX32;
    i.alt_bank = 1'b1;
    i.rx = 4'h1;
    i.ry = 4'h1;
    i.ra_dst = 4'hF;
    i.rm_dst = 4'hE;
    i.rs_dst = 4'h3;
    exec(48'(i));
    chk("fixed add", alu, {2{40'h00_0000_0006}});
    chk("fixed mul", mul, {2{40'h00_0000_0009}});
    i.mul_en = 1'b0;
    i.sh_en = 1'b0;
    i.alu_op = dsd_pkg::ALU_PASS;
    i.rx = 4'h3;
    exec(48'(i));
    chk("shift result", alu, {2{40'h00_0000_0018}});
  endtask

  task automatic s_single();
    en = 1'b0;
    repeat (3) step();
    chk("secondary idle", 80'(act), 80'h0);
    exec(op(1'b1, dsd_pkg::ALU_NEG, 1'b0, 4'h2, 1'b0, 4'h0));
    chk("x only", alu, {40'h01_1111_2222, 40'h00_0000_0018});
  endtask

  initial begin
    repeat (8) @(posedge CLK_IN);
    #1;
    RST_N_IN = 1'b1;
    chk("reset results", alu, 80'h0);
    s_cache();
    s_simd();
    s_bank();
    s_fixed();
    s_single();
    conclude();
  end
endmodule
